// ### verilog/plotter_port_order_processor.sv
// Order processor driving the serial plotter port from buffer storage
`timescale 1ns/100ps
`default_nettype none
module plotter_port_order_processor (
  input  wire logic                                clock,
  input  wire logic                                rst,
  input  wire logic                                enable,
  input  wire logic                                host_valid,
  input  wire plotter_order_pkg::host_req_t        host_req,
  output var  logic                                resp_valid_q,
  output var  plotter_order_pkg::host_resp_t       resp_q,
  output var  logic                                mem_rd_q,
  output var  logic [plotter_order_pkg::AW-1:0]    mem_addr_q,
  input  wire logic                                mem_valid,
  input  wire logic [15:0]                         mem_rdata,
  output var  logic                                tx_valid_q,
  output var  logic [7:0]                          tx_data_q,
  input  wire logic                                tx_ready,
  output var  logic                                running_q,
  output var  logic                                io_done_q,
  output var  logic [7:0]                          status0_q
);
  typedef enum logic [2:0] {S_IDLE, S_OP, S_ARG1, S_ARG2, S_IO_CONTROL_BLOCK, S_DATA, S_SEND, S_DONE} state_t;

  // Program sequencing registers
  state_t                          state_q;
  logic [15:0]                     op_q;
  logic [15:0]                     arg1_q;
  logic [15:0]                     data_reg_q;
  logic [plotter_order_pkg::AW-1:0] pc_q;
  logic [plotter_order_pkg::AW-1:0] addr_reg_q;
  logic [plotter_order_pkg::AW-1:0] io_control_block_ptr_q;
  logic [plotter_order_pkg::AW-1:0] data_ptr_q;
  logic [1:0]                      idx_q;
  logic [1:0]                      imm_idx_q;

  // Control block fields
  logic [7:0]                      cmd_q;
  logic [7:0]                      flags_q;
  logic [15:0]                     cnt_q;
  logic [15:0]                     w2_q;

  // Decode and fetch helpers
  logic [plotter_order_pkg::AW-1:0] fetch_addr;
  logic [7:0]                      imm_next;
  logic [3:0]                      cond;
  logic                            fetching;
  logic                            got;
  logic                            our_dev;
  logic                            do_start;
  logic                            do_stop;
  logic                            cmd_ok;
  logic                            three_word;
  logic [31:0]                     imm_word;
  logic [15:0]                     w3_q;

  // Host command decode for the plotter address only
  assign our_dev  = host_req.dev == plotter_order_pkg::PLOT_DEV_ADDR;
  assign do_start = host_valid && our_dev && host_req.cmd == plotter_order_pkg::HC_START;
  assign do_stop  = host_valid && our_dev && host_req.cmd == plotter_order_pkg::HC_STOP;

  // Word fetch bookkeeping
  assign fetching = state_q inside {S_OP, S_ARG1, S_ARG2, S_IO_CONTROL_BLOCK, S_DATA};
  assign got      = mem_rd_q && mem_valid && fetching;
  assign three_word = op_q == plotter_order_pkg::OP_IO || op_q == plotter_order_pkg::OP_BRMASK;
  assign cond = {1'b1, |status0_q, data_reg_q == 16'h0000, 1'b0};
  assign imm_word = {w2_q, w3_q};

  // Valid control block commands
  assign cmd_ok = cmd_q == plotter_order_pkg::CB_WRITE || cmd_q == plotter_order_pkg::CB_READ
               || cmd_q[5:0] == plotter_order_pkg::CB_CONTROL || cmd_q == plotter_order_pkg::CB_SENSE
               || cmd_q == plotter_order_pkg::CB_XFER_CTL;

  // Address of the word each fetching state needs; narrow sums wrap through zero
  always_comb begin
    case (state_q)
      S_ARG1:  fetch_addr = pc_q + plotter_order_pkg::STEP_WORD;
      S_ARG2:  fetch_addr = pc_q + plotter_order_pkg::STEP_TWO;
      S_IO_CONTROL_BLOCK:  fetch_addr = io_control_block_ptr_q + {12'h000, idx_q, 1'b0};
      S_DATA:  fetch_addr = {data_ptr_q[plotter_order_pkg::AW-1:1], 1'b0};
      default: fetch_addr = pc_q;
    endcase
  end

  // Next immediate byte, most significant first
  always_comb begin
    case (imm_idx_q)
      2'd0:    imm_next = imm_word[23:16];
      2'd1:    imm_next = imm_word[15:8];
      2'd2:    imm_next = imm_word[7:0];
      default: imm_next = imm_word[31:24];
    endcase
  end

  // Storage read request: held until answered, withdrawn when leaving a fetch state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_rd_q   <= 1'b0;
      mem_addr_q <= '0;
    end else if (enable) begin
      // Drop the request once answered, stopped or idle
      if (!fetching || do_stop || got) begin
        mem_rd_q <= 1'b0;
      end else if (!mem_rd_q) begin
        mem_rd_q   <= 1'b1;
        mem_addr_q <= fetch_addr;
      end
    end
  end

  // Host command answers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resp_valid_q <= 1'b0;
      resp_q       <= '0;
    end else if (enable) begin
      resp_valid_q <= host_valid && our_dev;
      resp_q       <= '0;
      // Fixed answers except sense, which returns status0_q; validity gated by the plotter address
      case (host_req.cmd)
        plotter_order_pkg::HC_INS_CUR, plotter_order_pkg::HC_REM_CUR,
        plotter_order_pkg::HC_RD_CUR:  resp_q.reject <= 1'b1;
        plotter_order_pkg::HC_RD_XY:   resp_q.data   <= 16'h0000;
        plotter_order_pkg::HC_RD_MAN,
        plotter_order_pkg::HC_SET_PFI: resp_q.reject <= 1'b1;
        plotter_order_pkg::HC_ALARM:   resp_q.reject <= 1'b0;
        plotter_order_pkg::HC_SENSE:   resp_q.data   <= {status0_q, 8'h00};
        plotter_order_pkg::HC_REFRESH: resp_q.reject <= 1'b1;
        default:                       resp_q.reject <= 1'b0;
      endcase
    end
  end

  // Order sequencing and control block execution
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q    <= S_IDLE;
      running_q  <= 1'b0;
      io_done_q  <= 1'b0;
      status0_q  <= '0;
      pc_q       <= '0;
      op_q       <= '0;
      arg1_q     <= '0;
      data_reg_q <= '0;
      addr_reg_q <= '0;
      io_control_block_ptr_q <= '0;
      data_ptr_q <= '0;
      idx_q      <= '0;
      imm_idx_q  <= '0;
      cmd_q      <= '0;
      flags_q    <= '0;
      cnt_q      <= '0;
      w2_q       <= '0;
      w3_q       <= '0;
      tx_valid_q <= 1'b0;
      tx_data_q  <= '0;
    end else if (enable) begin
      // Completion pulse lasts one cycle
      io_done_q <= 1'b0;
      // Stop outranks start, start outranks the running program
      if (do_stop) begin
        state_q    <= S_IDLE;
        running_q  <= 1'b0;
        tx_valid_q <= 1'b0;
      end else if (do_start) begin
        pc_q      <= host_req.addr;
        status0_q <= '0;
        running_q <= 1'b1;
        state_q   <= S_OP;
      end else begin
        case (state_q)
          // Opcode word: one-word orders finish here
          S_OP: if (got) begin
            // Orders with operands go on to fetch them
            op_q <= mem_rdata;
            if (mem_rdata == plotter_order_pkg::OP_EOS) begin
              state_q   <= S_IDLE;
              running_q <= 1'b0;
            end else if (mem_rdata == plotter_order_pkg::OP_NOP4) begin
              pc_q <= pc_q + plotter_order_pkg::STEP_TWO;
            end else if (mem_rdata == plotter_order_pkg::OP_MVA || mem_rdata == plotter_order_pkg::OP_MVD
                      || mem_rdata == plotter_order_pkg::OP_BRCNT || mem_rdata == plotter_order_pkg::OP_IO
                      || mem_rdata == plotter_order_pkg::OP_BRMASK
                      || mem_rdata[15:4] == plotter_order_pkg::OP_BRCOND_HI) begin
              state_q <= S_ARG1;
            end else begin
              pc_q <= pc_q + plotter_order_pkg::STEP_WORD;
            end
          end

          // First operand: moves and two-word branches end here
          S_ARG1: if (got) begin
            arg1_q <= mem_rdata;
            state_q <= three_word ? S_ARG2 : S_OP;
            if (!three_word) begin
              pc_q <= pc_q + plotter_order_pkg::STEP_TWO;
            end
            // Act on the operand by order
            if (op_q == plotter_order_pkg::OP_MVA) begin
              addr_reg_q <= mem_rdata[plotter_order_pkg::AW-1:0];
            end else if (op_q == plotter_order_pkg::OP_MVD) begin
              data_reg_q <= mem_rdata;
            end else if (op_q == plotter_order_pkg::OP_BRCNT) begin
              data_reg_q <= data_reg_q - 16'h0001;
              if (data_reg_q != 16'h0001) begin
                pc_q <= mem_rdata[plotter_order_pkg::AW-1:0];
              end
            end else if (op_q[15:4] == plotter_order_pkg::OP_BRCOND_HI && |(op_q[3:0] & cond)) begin
              pc_q <= mem_rdata[plotter_order_pkg::AW-1:0];
            end
          end

          // Second operand: mask branch target or block pointer
          S_ARG2: if (got) begin
            // Middle word is ignored; pointer forced even
            if (op_q == plotter_order_pkg::OP_IO) begin
              io_control_block_ptr_q <= {mem_rdata[plotter_order_pkg::AW-1:1], 1'b0};
              idx_q      <= '0;
              state_q    <= S_IO_CONTROL_BLOCK;
            end else begin
              state_q <= S_OP;
              pc_q    <= |(data_reg_q & arg1_q) ? mem_rdata[plotter_order_pkg::AW-1:0]
                                                : pc_q + plotter_order_pkg::STEP_IO;
            end
          end

          // Control block words arrive in order
          S_IO_CONTROL_BLOCK: if (got) begin
            idx_q <= idx_q + 2'd1;
            case (idx_q)
              2'd0:    {cmd_q, flags_q} <= mem_rdata;
              2'd1:    cnt_q <= mem_rdata;
              2'd2:    w2_q <= mem_rdata;
              default: w3_q <= mem_rdata;
            endcase
            // Last word in hand: act on the command
            if (idx_q == 2'd3) begin
              data_ptr_q <= mem_rdata[plotter_order_pkg::AW-1:0];
              imm_idx_q  <= '0;
              state_q    <= S_DONE;
              if (!cmd_ok) begin
                status0_q[plotter_order_pkg::ST_BADCMD] <= 1'b1;
              end else if (cmd_q == plotter_order_pkg::CB_WRITE && cnt_q != 16'h0000) begin
                if (flags_q[plotter_order_pkg::FLAG_IMM] && cnt_q > plotter_order_pkg::IMM_MAX) begin
                  status0_q[plotter_order_pkg::ST_LENGTH] <= !flags_q[plotter_order_pkg::FLAG_SLI];
                end else if (flags_q[plotter_order_pkg::FLAG_IMM]) begin
                  tx_data_q  <= w2_q[15:8];
                  tx_valid_q <= 1'b1;
                  state_q    <= S_SEND;
                end else begin
                  state_q <= S_DATA;
                end
              end
            end
          end

          // Pick the addressed byte from the fetched word
          S_DATA: if (got) begin
            tx_data_q  <= data_ptr_q[0] ? mem_rdata[7:0] : mem_rdata[15:8];
            tx_valid_q <= 1'b1;
            state_q    <= S_SEND;
          end

          // Byte taken: count down, then next byte or done
          S_SEND: if (tx_ready) begin
            tx_valid_q <= 1'b0;
            cnt_q      <= cnt_q - 16'h0001;
            data_ptr_q <= data_ptr_q + 15'h0001;
            imm_idx_q  <= imm_idx_q + 2'd1;
            // Count reaching zero ends the block
            if (cnt_q == 16'h0001) begin
              state_q <= S_DONE;
            end else if (flags_q[plotter_order_pkg::FLAG_IMM]) begin
              tx_data_q  <= imm_next;
              tx_valid_q <= 1'b1;
            end else begin
              state_q <= S_DATA;
            end
          end

          // Chain to the next block or resume the program
          S_DONE: begin
            idx_q <= '0;
            // Any status bit set breaks the chain
            if (flags_q[plotter_order_pkg::FLAG_CHN] && status0_q == 8'h00) begin
              io_control_block_ptr_q <= io_control_block_ptr_q + plotter_order_pkg::STEP_CB;
              state_q    <= S_IO_CONTROL_BLOCK;
            end else begin
              pc_q      <= pc_q + plotter_order_pkg::STEP_IO;
              io_done_q <= 1'b1;
              state_q   <= S_OP;
            end
          end

          // Idle; all eight state codes are named, so only S_IDLE lands here
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // plotter_port_order_processor
`default_nettype wire

// ### verilog/plotter_order_pkg.sv
// Constants and carrier types for the plotter port order processor
// Functional notes
// - Unsupported orders execute as no-operations
// - Decode nop, end, move address, move data
// - Decode io, branch condition, mask, count
// - Plotter port answers at lowest device address
// - Refresh to plotter address is refused
// - Program runs until end order or stop
// - Cursor commands to plotter get command reject
// - Read position returns all-zero X,Y value
// - Manual input, function indicators get reject
// - Audible alarm accepted, nothing done
// - Sense returns normal sense data; host filters
// - Buffer addresses wrap past 32767 to zero
// - Io order locates eight-byte control block
// - Start loads address, runs orders sequentially
// - Control blocks chain to further data areas
// - Transfer ends on zero count or stop
// - Io order is three sixteen-bit words
// - Control block address forced even
// - Bad control block command ends io order
// - Chaining stops once status byte nonzero
`default_nettype none
package plotter_order_pkg;
  localparam int AW = 15;                               // Byte address width: 32 KiB, wraps through zero
  localparam logic [15:0] OP_NOP2       = 16'h2A80;
  localparam logic [15:0] OP_EOS        = 16'h2A81;
  localparam logic [11:0] OP_NOP2_HI    = 12'h2AB;      // 2AB0..2ABF
  localparam logic [15:0] OP_NOP4       = 16'h2AC0;
  localparam logic [15:0] OP_MVA        = 16'h2AEB;
  localparam logic [15:0] OP_MVD        = 16'h2AEC;
  localparam logic [15:0] OP_IO         = 16'h2A89;
  localparam logic [11:0] OP_BRCOND_HI  = 12'h2A7;      // 2A70..2A7F
  localparam logic [15:0] OP_BRMASK     = 16'h2AED;
  localparam logic [15:0] OP_BRCNT      = 16'h2AF0;
  localparam logic [7:0]  CB_WRITE      = 8'h01;
  localparam logic [7:0]  CB_READ       = 8'h02;
  localparam logic [5:0]  CB_CONTROL    = 6'h03;        // Low six bits; top two select subcommand
  localparam logic [7:0]  CB_SENSE      = 8'h04;
  localparam logic [7:0]  CB_XFER_CTL   = 8'h08;
  localparam int FLAG_IMM  = 2;
  localparam int FLAG_CHN  = 1;
  localparam int FLAG_SLI  = 0;
  localparam int ST_BADCMD = 7;                         // Status byte 0: invalid block command
  localparam int ST_LENGTH = 6;                         // Status byte 0: incorrect length
  localparam logic [15:0] IMM_MAX     = 16'h0004;
  localparam logic [AW-1:0] STEP_WORD = 15'h0002;
  localparam logic [AW-1:0] STEP_TWO  = 15'h0004;
  localparam logic [AW-1:0] STEP_IO   = 15'h0006;
  localparam logic [AW-1:0] STEP_CB   = 15'h0008;       // Control block length in bytes
  localparam logic [7:0]  PLOT_DEV_ADDR = 8'h00;        // Lowest device address of the controller
  localparam int COND_ALWAYS = 3;
  localparam int COND_STATUS = 2;
  localparam int COND_ZERO   = 1;

  typedef enum logic [3:0] {
    HC_NOP, HC_START, HC_STOP, HC_INS_CUR, HC_REM_CUR, HC_RD_CUR, HC_RD_XY,
    HC_RD_MAN, HC_SET_PFI, HC_ALARM, HC_SENSE, HC_REFRESH
  } host_cmd_t;

  typedef struct packed {
    host_cmd_t     cmd;
    logic [7:0]    dev;
    logic [AW-1:0] addr;
  } host_req_t;

  typedef struct packed {
    logic        reject;
    logic [15:0] data;
  } host_resp_t;
endpackage
`default_nettype wire

// ### dv/plotter_port_properties.sv
// Port assertions for the plotter port order processor
`timescale 1ns/100ps
`default_nettype none
module plotter_port_checker (
  input wire logic                          clock,
  input wire logic                          rst,
  input wire logic                          enable,
  input wire logic                          host_valid,
  input wire plotter_order_pkg::host_req_t  host_req,
  input wire logic                          resp_valid_q,
  input wire plotter_order_pkg::host_resp_t resp_q,
  input wire logic                          mem_rd_q,
  input wire logic [14:0]                   mem_addr_q,
  input wire logic                          mem_valid,
  input wire logic                          tx_valid_q,
  input wire logic [7:0]                    tx_data_q,
  input wire logic                          tx_ready,
  input wire logic                          running_q,
  input wire logic                          io_done_q
);
  default clocking cb_main @(posedge clock);
  endclocking
  default disable iff (rst);
  logic take;
  logic stop_now;
  // Commands taken for the plotter address, and the stop among them
  assign take = enable && host_valid && host_req.dev == plotter_order_pkg::PLOT_DEV_ADDR;
  assign stop_now = take && host_req.cmd == plotter_order_pkg::HC_STOP;
  sequence s_cmd(c);
    take && host_req.cmd == c;
  endsequence
  sequence s_ok_zero;
    resp_valid_q && !resp_q.reject && resp_q.data == 16'h0000;
  endsequence
  AST_RESP_DEV0: assert property (take |=> resp_valid_q) else $error("plotter command unanswered");
  AST_RESP_OTHER: assert property (enable && host_valid && host_req.dev != 8'h00 |=> !resp_valid_q)
    else $error("answer to another device");
  AST_REJECT: assert property (take && host_req.cmd inside {plotter_order_pkg::HC_INS_CUR,
    plotter_order_pkg::HC_REM_CUR, plotter_order_pkg::HC_RD_CUR, plotter_order_pkg::HC_RD_MAN,
    plotter_order_pkg::HC_SET_PFI, plotter_order_pkg::HC_REFRESH} |=> resp_valid_q && resp_q.reject)
    else $error("command not rejected");
  AST_XY_ZERO: assert property (s_cmd(plotter_order_pkg::HC_RD_XY) |=> s_ok_zero)
    else $error("position value not zero");
  AST_ALARM: assert property (s_cmd(plotter_order_pkg::HC_ALARM) |=> s_ok_zero) else $error("alarm refused");
  AST_SENSE: assert property (s_cmd(plotter_order_pkg::HC_SENSE) |=>
    resp_valid_q && !resp_q.reject && resp_q.data[7:0] == 8'h00) else $error("sense answer wrong");
  AST_STOP: assert property (s_cmd(plotter_order_pkg::HC_STOP) |-> ##[1:2] (!running_q && !tx_valid_q && !mem_rd_q))
    else $error("stop not obeyed");
  AST_MEM_HOLD: assert property (mem_rd_q && !mem_valid && enable && !stop_now |=> mem_rd_q && $stable(mem_addr_q))
    else $error("read request dropped");
  AST_TX_HOLD: assert property (tx_valid_q && !tx_ready && enable && !stop_now |=> tx_valid_q && $stable(tx_data_q))
    else $error("port byte dropped");
  AST_ADDR_EVEN: assert property (mem_rd_q |-> !mem_addr_q[0]) else $error("odd fetch address");
  AST_IO_PULSE: assert property (io_done_q && enable |=> !io_done_q) else $error("io done not a pulse");
endmodule // plotter_port_checker
bind plotter_port_order_processor plotter_port_checker i_chk (.clock(clock), .rst(rst), .enable(enable),
  .host_valid(host_valid), .host_req(host_req), .resp_valid_q(resp_valid_q), .resp_q(resp_q),
  .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q), .mem_valid(mem_valid), .tx_valid_q(tx_valid_q),
  .tx_data_q(tx_data_q), .tx_ready(tx_ready), .running_q(running_q), .io_done_q(io_done_q));
`default_nettype wire

// ### dv/plotter_far_side.sv
// Buffer storage and serial port adapter model facing the order processor
`timescale 1ns/100ps
`default_nettype none
module plotter_far_side (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        stall,
  input  wire logic        mem_rd_q,
  input  wire logic [14:0] mem_addr_q,
  output var  logic        mem_valid,
  output var  logic [15:0] mem_rdata,
  input  wire logic        tx_valid_q,
  input  wire logic [7:0]  tx_data_q,
  output var  logic        tx_ready
);
  logic [15:0] mem [16384];
  logic        seen [32768];
  logic [7:0]  got [$];
  logic [1:0]  wait_q;
  // Storage answers after one or three cycles; idle data toggles
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_valid <= 1'b0;
      wait_q <= 2'h0;
      mem_rdata <= 16'h0000;
    end else if (!mem_rd_q || mem_valid) begin
      mem_valid <= 1'b0;
      wait_q <= 2'h0;
      mem_rdata <= ~mem_rdata;
    end else begin
      wait_q <= wait_q + 2'h1;
      mem_valid <= wait_q == (slow ? 2'h2 : 2'h0);
      mem_rdata <= (wait_q == (slow ? 2'h2 : 2'h0)) ? mem[mem_addr_q[14:1]] : ~mem_rdata;
      seen[mem_addr_q] <= 1'b1;
    end
  end
  // Adapter takes bytes unless stalled and records them
  assign tx_ready = !stall;
  always @(posedge clock)
    if (!rst && tx_valid_q && tx_ready) got.push_back(tx_data_q);
endmodule // plotter_far_side
`default_nettype wire

// ### dv/test_plotter_port_order_processor.sv
// Self-checking bench for the plotter port order processor
`timescale 1ns/100ps
`default_nettype none
module test_plotter_port_order_processor;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic enable = 1'b1;
  logic host_valid = 1'b0;
  plotter_order_pkg::host_req_t host_req = '0;
  logic slow = 1'b0;
  logic stall = 1'b0;
  logic resp_valid_q, mem_rd_q, mem_valid, tx_valid_q, tx_ready, running_q, io_done_q;
  plotter_order_pkg::host_resp_t resp_q;
  logic [14:0] mem_addr_q;
  logic [15:0] mem_rdata;
  logic [7:0] tx_data_q, status0_q;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int dones = 0;
  plotter_port_order_processor i_dut (.clock(clock), .rst(rst), .enable(enable), .host_valid(host_valid),
    .host_req(host_req), .resp_valid_q(resp_valid_q), .resp_q(resp_q), .mem_rd_q(mem_rd_q),
    .mem_addr_q(mem_addr_q), .mem_valid(mem_valid), .mem_rdata(mem_rdata), .tx_valid_q(tx_valid_q),
    .tx_data_q(tx_data_q), .tx_ready(tx_ready), .running_q(running_q), .io_done_q(io_done_q), .status0_q(status0_q));
  plotter_far_side i_far (.clock(clock), .rst(rst), .slow(slow), .stall(stall), .mem_rd_q(mem_rd_q),
    .mem_addr_q(mem_addr_q), .mem_valid(mem_valid), .mem_rdata(mem_rdata), .tx_valid_q(tx_valid_q),
    .tx_data_q(tx_data_q), .tx_ready(tx_ready));
  always #12.5 clock = ~clock;
  // Count io completions and cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (io_done_q === 1'b1) dones++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic load(input logic [14:0] a, input logic [15:0] w [$]);
    foreach (w[k]) i_far.mem[a[14:1] + 14'(k)] = w[k];
  endtask
  // One host command; the answer is sampled the cycle after it is taken
  task automatic host(input plotter_order_pkg::host_cmd_t c, input logic [7:0] d, input logic [14:0] a,
                      output logic v, output plotter_order_pkg::host_resp_t r);
    @(posedge clock);
    host_valid <= 1'b1;
    host_req <= {c, d, a};
    @(posedge clock);
    host_valid <= 1'b0;
    #1;
    v = resp_valid_q;
    r = resp_q;
  endtask
  // Start a program and wait until it ends by itself
  task automatic run(input logic [14:0] a);
    logic v;
    plotter_order_pkg::host_resp_t r;
    int n;
    foreach (i_far.seen[k]) i_far.seen[k] = 1'b0;
    i_far.got.delete();
    host(plotter_order_pkg::HC_START, 8'h00, a, v, r);
    chk({15'h0, running_q}, 16'h0001);
    n = 0;
    while (running_q !== 1'b0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    chk({15'h0, running_q}, 16'h0000);
  endtask
  // Every side command, to the plotter address and to another
  task automatic t_cmds();
    logic v;
    plotter_order_pkg::host_resp_t r;
    for (int i = 0; i < 12; i++) begin
      if (i == 1 || i == 2) continue;
      host(plotter_order_pkg::host_cmd_t'(i), 8'h00, 15'h0000, v, r);
      chk({14'h0, v, r.reject}, {14'h0, 1'b1, 1'(i inside {3, 4, 5, 7, 8, 11})});
      if (r.reject === 1'b0) chk(i == 10 ? {8'h00, r.data[7:0]} : r.data, 16'h0000);
      host(plotter_order_pkg::host_cmd_t'(i), 8'h03, 15'h0000, v, r);
      chk({15'h0, v}, 16'h0000);
    end
  endtask
  // Filler orders, odd block pointer, chained data and immediate blocks
  task automatic t_io();
    logic [7:0] exp_b [5] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hE5};
    int d0;
    slow <= 1'b1;
    load(15'h0100, '{16'h2A80, 16'h2AB5, 16'h2AC0, 16'h5555, 16'h1234, 16'h2A89, 16'hFFFF, 16'h0201, 16'h2A81});
    load(15'h0200, '{16'h0102, 16'h0002, 16'h0000, 16'h0300, 16'h0104, 16'h0003, 16'hC3D4, 16'hE5F6});
    load(15'h0300, '{16'hA1B2});
    d0 = dones;
    run(15'h0100);
    chk(16'(dones - d0), 16'h0001);
    chk(16'(i_far.got.size()), 16'h0005);
    for (int k = 0; k < 5 && k < i_far.got.size(); k++) chk({8'h00, i_far.got[k]}, {8'h00, exp_b[k]});
    chk({15'h0, i_far.seen[15'h0200]}, 16'h0001);
    slow <= 1'b0;
  endtask
  // Moves and branches straddling the top of storage
  task automatic t_wrap();
    load(15'h7FF8, '{16'h2AEC, 16'h0001, 16'h2AEB, 16'h0100});
    load(15'h0000, '{16'h2A78, 16'h0040, 16'h2A81});
    load(15'h0040, '{16'h2AF0, 16'h0050, 16'h2AED, 16'h0001, 16'h0060, 16'h2A81});
    load(15'h0050, '{16'h2A81});
    load(15'h0060, '{16'h2A81});
    run(15'h7FF8);
    chk({15'h0, i_far.seen[15'h0000]}, 16'h0001);
    chk({i_far.seen[15'h0004], i_far.seen[15'h0040], i_far.seen[15'h0050], i_far.seen[15'h0060]}, 16'h0004);
  endtask
  // Stop while a byte waits on a stalled adapter
  task automatic t_stop();
    logic v;
    plotter_order_pkg::host_resp_t r;
    int d0;
    int n;
    stall <= 1'b1;
    load(15'h0400, '{16'h0100, 16'h0008, 16'h0000, 16'h0500});
    load(15'h0500, '{16'h1122});
    load(15'h0410, '{16'h2A89, 16'h0000, 16'h0400, 16'h2A81});
    d0 = dones;
    host(plotter_order_pkg::HC_START, 8'h00, 15'h0410, v, r);
    n = 0;
    while (tx_valid_q !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    chk({8'h00, tx_data_q}, 16'h0011);
    host(plotter_order_pkg::HC_STOP, 8'h00, 15'h0000, v, r);
    chk({14'h0, running_q, tx_valid_q}, 16'h0000);
    chk(16'(dones - d0), 16'h0000);
    stall <= 1'b0;
  endtask
  // Invalid block command with chaining set ends the io order
  task automatic t_bad();
    int d0;
    load(15'h0600, '{16'h0502, 16'h0001, 16'h0000, 16'h0700, 16'h0100, 16'h0001, 16'h0000, 16'h0700});
    load(15'h0620, '{16'h2A89, 16'h0000, 16'h0600, 16'h2A81});
    d0 = dones;
    run(15'h0620);
    chk({15'h0, status0_q[7]}, 16'h0001);
    chk({15'h0, i_far.seen[15'h0608]}, 16'h0000);
    chk(16'(dones - d0 + i_far.got.size()), 16'h0001);
    // Over-long immediate write flags length and breaks its chain
    load(15'h0640, '{16'h0106, 16'h0005, 16'h0000, 16'h0000, 16'h0101, 16'h0001, 16'h0000, 16'h0000});
    load(15'h0660, '{16'h2A89, 16'h0000, 16'h0640, 16'h2A81});
    run(15'h0660);
    chk({8'h00, status0_q}, 16'h0040);
    chk({15'h0, i_far.seen[15'h0648]}, 16'h0000);
    chk(16'(i_far.got.size()), 16'h0000);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_cmds();
    t_io();
    t_wrap();
    t_stop();
    t_bad();
    test_done();
  end
endmodule // test_plotter_port_order_processor
`default_nettype wire
